// >>> logic/ext_osc_sync.sv
`timescale 1ns/1ns
// two-flop synchroniser plus rising-edge detect on the second stage
module ext_osc_sync
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_ext_osc,
  output logic      o_rise
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  always_comb
  begin
    sync_next = {sync_reg[1:0], i_ext_osc};
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
      sync_reg <= 3'b000;
    else
      sync_reg <= sync_next;
  end

  assign o_rise = sync_reg[1] & ~sync_reg[2];
endmodule

// >>> logic/tick_divider.sv
`timescale 1ns/1ns
// divides a stream of input enables by a fixed count, one-cycle pulse out
module tick_divider
  import timer2_pkg::*;
#(
  parameter logic [3:0] DIV = 4'd12
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  input  wire logic i_tick,
  output logic      o_tick
);
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic       pulse_reg;
  logic       pulse_next;

  always_comb
  begin
    cnt_next   = cnt_reg;
    pulse_next = 1'b0;
    if (i_tick)
    begin
      if (cnt_reg == DIV - 4'd1)
      begin
        cnt_next   = 4'd0;
        pulse_next = 1'b1;
      end
      else
        cnt_next = cnt_reg + 4'd1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg   <= 4'd0;
      pulse_reg <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign o_tick = pulse_reg;
endmodule

// >>> logic/timer2.sv
`timescale 1ns/1ns
module timer2
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ext_osc,
  input  wire logic       i_timer_irq_enable,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_wr,
  input  wire logic       i_sfr_rd,
  output logic      [7:0] o_sfr_rdata,
  output logic            o_sfr_hit,
  output logic            o_irq
);
  import timer2_pkg::*;

  logic [7:0] clk_ctl_reg;
  logic [7:0] clk_ctl_next;
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [7:0] rl_lo_reg;
  logic [7:0] rl_lo_next;
  logic [7:0] rl_hi_reg;
  logic [7:0] rl_hi_next;
  logic [7:0] cnt_lo_reg;
  logic [7:0] cnt_lo_next;
  logic [7:0] cnt_hi_reg;
  logic [7:0] cnt_hi_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       hit_reg;
  logic       hit_next;

  logic ext_rise;
  logic ext_tick;
  logic sys12_tick;
  logic tick_hi;
  logic tick_lo;
  logic split;
  logic run;
  logic ext_sel;
  logic wr_ctl;
  logic wr_lo;
  logic wr_hi;
  logic ovf_lo;
  logic ovf_hi;
  logic irq_lo_en;

  ext_osc_sync u_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_ext_osc (i_ext_osc),
    .o_rise    (ext_rise)
  );

  // oscillator edges counted only after synchronising
  tick_divider #(.DIV(EXT_DIV)) u_ext_div
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_tick    (ext_rise),
    .o_tick    (ext_tick)
  );

  tick_divider #(.DIV(SYS_DIV)) u_sys_div
  (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_tick    (1'b1),
    .o_tick    (sys12_tick)
  );

  assign split   = ctl_reg[SPLIT_BIT];
  assign run     = ctl_reg[RUN_BIT];
  assign ext_sel = ctl_reg[EXT_SEL_BIT];

  always_comb
  begin
    // select bit high means every system clock cycle
    if (clk_ctl_reg[HI_SEL_BIT])
      tick_hi = 1'b1;
    else if (ext_sel)
      tick_hi = ext_tick;
    else
      tick_hi = sys12_tick;
    // the low select also drives the joined 16-bit count
    if (clk_ctl_reg[LO_SEL_BIT])
      tick_lo = 1'b1;
    else if (ext_sel)
      tick_lo = ext_tick;
    else
      tick_lo = sys12_tick;
  end

  assign wr_ctl = i_sfr_wr && (i_sfr_addr == TMR_CTL_ADDR);
  assign wr_lo  = i_sfr_wr && (i_sfr_addr == COUNT_LO_ADDR);
  assign wr_hi  = i_sfr_wr && (i_sfr_addr == COUNT_HI_ADDR);

  always_comb
  begin
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    ovf_lo      = 1'b0;
    ovf_hi      = 1'b0;
    if (split)
    begin
      // low byte runs regardless of run control
      if (tick_lo)
      begin
        if (cnt_lo_reg == 8'hFF)
        begin
          cnt_lo_next = rl_lo_reg;
          ovf_lo      = 1'b1;
        end
        else
          cnt_lo_next = cnt_lo_reg + 8'h01;
      end
      if (run && tick_hi)
      begin
        if (cnt_hi_reg == 8'hFF)
        begin
          cnt_hi_next = rl_hi_reg;
          ovf_hi      = 1'b1;
        end
        else
          cnt_hi_next = cnt_hi_reg + 8'h01;
      end
    end
    else if (run && tick_lo)
    begin
      if (cnt_lo_reg == 8'hFF)
        ovf_lo = 1'b1; // low wrap noted for its own irq
      if ({cnt_hi_reg, cnt_lo_reg} == 16'hFFFF)
      begin
        {cnt_hi_next, cnt_lo_next} = {rl_hi_reg, rl_lo_reg};
        ovf_hi = 1'b1;
      end
      else
        {cnt_hi_next, cnt_lo_next} =
          {cnt_hi_reg, cnt_lo_reg} + 16'h0001;
    end
    // software write beats a same-cycle increment
    if (wr_lo)
      cnt_lo_next = i_sfr_wdata;
    if (wr_hi)
      cnt_hi_next = i_sfr_wdata;
  end

  always_comb
  begin
    clk_ctl_next = clk_ctl_reg;
    rl_lo_next   = rl_lo_reg;
    rl_hi_next   = rl_hi_reg;
    ctl_next     = ctl_reg;
    if (i_sfr_wr && (i_sfr_addr == CLK_CTL_ADDR))
      clk_ctl_next = i_sfr_wdata;
    else if (i_sfr_wr && (i_sfr_addr == RELOAD_LO_ADDR))
      rl_lo_next = i_sfr_wdata;
    else if (i_sfr_wr && (i_sfr_addr == RELOAD_HI_ADDR))
      rl_hi_next = i_sfr_wdata;
    if (wr_ctl)
      ctl_next = i_sfr_wdata & TMR_CTL_MASK;
    // hardware only sets flags; a set beats a same-cycle clear
    if (ovf_hi)
      ctl_next[HI_FLAG_BIT] = 1'b1;
    if (ovf_lo && split)
      ctl_next[LO_FLAG_BIT] = 1'b1;
    // in 16-bit mode the low flag reports low wraps when enabled
    if (ovf_lo && !split && ctl_reg[LO_IEN_BIT])
      ctl_next[LO_FLAG_BIT] = 1'b1;
  end

  always_comb
  begin
    hit_next   = 1'b0;
    rdata_next = 8'h00;
    if (i_sfr_addr == CLK_CTL_ADDR)
    begin
      hit_next   = 1'b1;
      rdata_next = clk_ctl_reg;
    end
    else if (i_sfr_addr == TMR_CTL_ADDR)
    begin
      hit_next   = 1'b1;
      rdata_next = ctl_reg;
    end
    else if (i_sfr_addr == RELOAD_LO_ADDR)
    begin
      hit_next   = 1'b1;
      rdata_next = rl_lo_reg;
    end
    else if (i_sfr_addr == RELOAD_HI_ADDR)
    begin
      hit_next   = 1'b1;
      rdata_next = rl_hi_reg;
    end
    else if (i_sfr_addr == COUNT_LO_ADDR)
    begin
      hit_next   = 1'b1;
      rdata_next = cnt_lo_reg;
    end
    else if (i_sfr_addr == COUNT_HI_ADDR)
    begin
      hit_next   = 1'b1;
      rdata_next = cnt_hi_reg;
    end
    if (!i_sfr_rd)
    begin
      hit_next   = 1'b0;
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      clk_ctl_reg <= CLK_CTL_RESET;
      ctl_reg     <= TMR_CTL_RESET;
      rl_lo_reg   <= BYTE_RESET;
      rl_hi_reg   <= BYTE_RESET;
      cnt_lo_reg  <= BYTE_RESET;
      cnt_hi_reg  <= BYTE_RESET;
      rdata_reg   <= BYTE_RESET;
      hit_reg     <= 1'b0;
    end
    else
    begin
      clk_ctl_reg <= clk_ctl_next;
      ctl_reg     <= ctl_next;
      rl_lo_reg   <= rl_lo_next;
      rl_hi_reg   <= rl_hi_next;
      cnt_lo_reg  <= cnt_lo_next;
      cnt_hi_reg  <= cnt_hi_next;
      rdata_reg   <= rdata_next;
      hit_reg     <= hit_next;
    end
  end

  // level request follows the high flag, and the low flag only while its enable bit is set
  assign irq_lo_en = ctl_reg[LO_IEN_BIT] & ctl_reg[LO_FLAG_BIT];
  assign o_irq = i_timer_irq_enable &
                 (ctl_reg[HI_FLAG_BIT] | irq_lo_en);
  assign o_sfr_rdata = rdata_reg;
  assign o_sfr_hit   = hit_reg;
endmodule

// >>> logic/timer2_pkg.sv
package timer2_pkg;
  localparam logic [7:0] CLK_CTL_ADDR   = 8'h8E;
  localparam logic [7:0] TMR_CTL_ADDR   = 8'hC8;
  localparam logic [7:0] RELOAD_LO_ADDR = 8'hCA;
  localparam logic [7:0] RELOAD_HI_ADDR = 8'hCB;
  localparam logic [7:0] COUNT_LO_ADDR  = 8'hCC;
  localparam logic [7:0] COUNT_HI_ADDR  = 8'hCD;
  localparam logic [7:0] CLK_CTL_RESET  = 8'h00;
  localparam logic [7:0] TMR_CTL_RESET  = 8'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  localparam int HI_SEL_BIT   = 5;
  localparam int LO_SEL_BIT   = 4;
  localparam int HI_FLAG_BIT  = 7;
  localparam int LO_FLAG_BIT  = 6;
  localparam int LO_IEN_BIT   = 5;
  localparam int SPLIT_BIT    = 3;
  localparam int RUN_BIT      = 2;
  localparam int EXT_SEL_BIT  = 0;
  localparam logic [7:0] TMR_CTL_MASK = 8'hED;
  localparam logic [3:0] SYS_DIV      = 4'd12;
  localparam logic [3:0] EXT_DIV      = 4'd8;
endpackage

// >>> sim/sfr_core_model.sv
`timescale 1ns/1ns
// tasks are entered just after a falling edge and return just after one
module sfr_core_model
  import timer2_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial {o_addr, o_wdata, o_wr, o_rd} = 18'h0_0000;
  // strobes stay up until the next transfer or idle, so no line is
  // assigned twice at one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    o_rd = 1'b0;
    @(negedge i_ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    o_addr = a;
    o_wr = 1'b0;
    o_rd = 1'b1;
    @(negedge i_ref_clk);
    d = i_rdata;
  endtask
  // released lines show the inverse so a stale value never looks valid
  task automatic idle(input int n);
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = ~o_addr;
    o_wdata = ~o_wdata;
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic service(output logic [7:0] d);
    rd(TMR_CTL_ADDR, d);
    wr(TMR_CTL_ADDR, d & 8'h3F);
  endtask
endmodule

// >>> sim/tb_timer2.sv
`timescale 1ns/1ns
module tb_timer2;
  import timer2_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ext = 1'b0;
  logic       ext_on = 1'b0;
  logic       ien = 1'b0;
  logic [7:0] addr, wdata, rdata, v, d;
  logic       wr, rd, hit, irq;
  int         error_cnt = 0;
  int         cmp_count = 0;
  int         seed = 32'h11ef;
  logic [7:0] maps [6] = '{CLK_CTL_ADDR, TMR_CTL_ADDR, RELOAD_LO_ADDR,
                           RELOAD_HI_ADDR, COUNT_LO_ADDR, COUNT_HI_ADDR};
  sfr_core_model core_u (.i_ref_clk(clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  timer2 dut_u (.i_ref_clk(clk), .i_rst(rst), .i_ext_osc(ext),
    .i_timer_irq_enable(ien), .i_sfr_addr(addr), .i_sfr_wdata(wdata),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .o_irq(irq));
  initial
  begin
    forever #25 clk = ~clk;
  end
  // oscillator stands low while unused, 8-cycle period when on
  initial
  begin
    forever
    begin
      repeat (4) @(negedge clk);
      ext = ext_on ? ~ext : 1'b0;
    end
  end
  function automatic logic [7:0] ctl(input logic s, r, l);
    ctl = 8'h00;
    ctl[SPLIT_BIT] = s;
    ctl[RUN_BIT] = r;
    ctl[LO_IEN_BIT] = l;
  endfunction
  // divider phase is free running, so timed counts get a tolerance
  task automatic chk(input logic [7:0] got, exp, input int tol);
    cmp_count++;
    if ($isunknown(got) || got > exp + tol || got + tol < exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, exp, input int tol);
    core_u.rd(a, d);
    chk(d, exp, tol);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #400000;
    error_cnt++;
    $display("mismatch at %0t: watchdog", $time);
    report_and_stop();
  end
  initial
  begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    foreach (maps[i]) rchk(maps[i], 8'h00, 0);
    rchk(8'h00, 8'h00, 0);
    repeat (8)
    begin
      v = $random(seed);
      foreach (maps[i])
      begin
        core_u.wr(maps[i], (i == 1) ? v & 8'hF3 : v);
        rchk(maps[i], (i == 1) ? v & 8'hF3 & TMR_CTL_MASK : v, 0);
      end
    end
    core_u.wr(TMR_CTL_ADDR, 8'h00);
    $display("test registers done");
    core_u.wr(CLK_CTL_ADDR, 8'h10);
    core_u.wr(RELOAD_LO_ADDR, 8'h34);
    core_u.wr(RELOAD_HI_ADDR, 8'h12);
    core_u.wr(COUNT_LO_ADDR, 8'hF0);
    core_u.wr(COUNT_HI_ADDR, 8'hFF);
    ien = 1'b1;
    core_u.wr(TMR_CTL_ADDR, ctl(0, 1, 0));
    core_u.idle(18);
    rchk(COUNT_HI_ADDR, 8'h12, 0);
    rchk(TMR_CTL_ADDR, ctl(0, 1, 0) | 8'h80, 0);
    chk({7'h00, irq}, 8'h01, 0);
    ien = 1'b0;
    core_u.idle(1);
    chk({7'h00, irq}, 8'h00, 0);
    ien = 1'b1;
    core_u.idle(100);
    chk({7'h00, irq}, 8'h01, 0);
    core_u.service(v);
    chk({7'h00, irq}, 8'h00, 0);
    core_u.wr(COUNT_LO_ADDR, 8'hF0);
    rchk(COUNT_LO_ADDR, 8'hF0, 0);
    core_u.wr(COUNT_HI_ADDR, 8'h00);
    core_u.wr(TMR_CTL_ADDR, ctl(0, 1, 1));
    core_u.idle(18);
    rchk(COUNT_HI_ADDR, 8'h01, 0);
    rchk(TMR_CTL_ADDR, ctl(0, 1, 1) | 8'h40, 0);
    chk({7'h00, irq}, 8'h01, 0);
    core_u.wr(TMR_CTL_ADDR, 8'h00);
    $display("test sixteen bit done");
    core_u.wr(COUNT_HI_ADDR, 8'h55);
    core_u.wr(RELOAD_LO_ADDR, 8'hA0);
    core_u.wr(COUNT_LO_ADDR, 8'hF8);
    core_u.wr(TMR_CTL_ADDR, ctl(1, 0, 0));
    core_u.idle(12);
    rchk(COUNT_LO_ADDR, 8'hA4, 0);
    rchk(COUNT_HI_ADDR, 8'h55, 0);
    rchk(TMR_CTL_ADDR, ctl(1, 0, 0) | 8'h40, 0);
    chk({7'h00, irq}, 8'h00, 0);
    core_u.wr(TMR_CTL_ADDR, ctl(1, 0, 1) | 8'h40);
    chk({7'h00, irq}, 8'h01, 0);
    core_u.wr(COUNT_HI_ADDR, 8'hFC);
    core_u.wr(RELOAD_HI_ADDR, 8'h77);
    core_u.wr(CLK_CTL_ADDR, 8'h30);
    core_u.wr(TMR_CTL_ADDR, ctl(1, 1, 0));
    core_u.idle(12);
    rchk(TMR_CTL_ADDR, ctl(1, 1, 0) | 8'h80, 0);
    chk({7'h00, irq}, 8'h01, 0);
    rchk(COUNT_HI_ADDR, 8'h80, 0);
    core_u.wr(TMR_CTL_ADDR, 8'h00);
    core_u.wr(CLK_CTL_ADDR, 8'h00);
    core_u.wr(COUNT_LO_ADDR, 8'h00);
    core_u.wr(COUNT_HI_ADDR, 8'h00);
    core_u.wr(TMR_CTL_ADDR, ctl(1, 1, 0));
    core_u.idle(240);
    rchk(COUNT_LO_ADDR, 8'h14, 1);
    rchk(COUNT_HI_ADDR, 8'h14, 1);
    core_u.wr(TMR_CTL_ADDR, 8'h00);
    core_u.wr(COUNT_LO_ADDR, 8'h00);
    core_u.wr(COUNT_HI_ADDR, 8'h00);
    ext_on = 1'b1;
    core_u.wr(TMR_CTL_ADDR, ctl(0, 1, 0) | (8'h01 << EXT_SEL_BIT));
    core_u.idle(640);
    rchk(COUNT_LO_ADDR, 8'h0A, 1);
    $display("test clock select done");
    report_and_stop();
  end
endmodule

// >>> sim/timer2_monitor.sv
`timescale 1ns/1ns
module timer2_monitor
  import timer2_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_timer_irq_enable,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_wr,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_sfr_hit,
  input wire logic       o_irq
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  logic map;
  assign map = i_sfr_addr inside {CLK_CTL_ADDR, TMR_CTL_ADDR, RELOAD_LO_ADDR,
                                  RELOAD_HI_ADDR, COUNT_LO_ADDR, COUNT_HI_ADDR};
  sequence wr_at(logic [7:0] a);
    i_sfr_wr && i_sfr_addr == a;
  endsequence
  sequence rd_at(logic [7:0] a);
    i_sfr_rd && !i_sfr_wr && i_sfr_addr == a;
  endsequence
  property wr_then_rd(logic [7:0] a);
    wr_at(a) ##1 rd_at(a) |=> o_sfr_rdata == $past(i_sfr_wdata, 2);
  endproperty
  clk_ctl_rb_a: assert property (wr_then_rd(CLK_CTL_ADDR))
    else $error("clock control readback wrong");
  reload_lo_rb_a: assert property (wr_then_rd(RELOAD_LO_ADDR))
    else $error("low reload readback wrong");
  reload_hi_rb_a: assert property (wr_then_rd(RELOAD_HI_ADDR))
    else $error("high reload readback wrong");
  mapped_hit_a: assert property (i_sfr_rd && map |=> o_sfr_hit)
    else $error("mapped read without hit");
  unmapped_zero_a: assert property (i_sfr_rd && !map |=>
    !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("unmapped read answered");
  idle_zero_a: assert property (!i_sfr_rd |=>
    !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("idle bus not zero");
  ctl_unused_a: assert property (rd_at(TMR_CTL_ADDR) |=>
    o_sfr_rdata[4] == 1'b0 && o_sfr_rdata[1] == 1'b0)
    else $error("unused control bits read high");
  irq_gate_a: assert property (!i_timer_irq_enable |-> !o_irq)
    else $error("irq while disabled");
  flag_hold_a: assert property ($fell(o_irq) |->
    $fell(i_timer_irq_enable) || $past(i_sfr_wr && i_sfr_addr == TMR_CTL_ADDR))
    else $error("irq dropped without software");
endmodule
bind timer2 timer2_monitor mon_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_timer_irq_enable(i_timer_irq_enable), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wdata(i_sfr_wdata), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
  .o_sfr_rdata(o_sfr_rdata), .o_sfr_hit(o_sfr_hit), .o_irq(o_irq));
